// *** cif_consts.svh ***
// Constants for the charger serial port and fault reporting block
`ifndef CIF_CONSTS_SVH
`define CIF_CONSTS_SVH
`define CIF_SLV_ADDR 7'h6a
`define CIF_NREG 10
`define CIF_IDX_MULTI_END 8'h08
`define CIF_IDX_WARM 8'h09
`define CIF_IDX_FAULT 8'h0c
`define CIF_IDX_BAD 8'hff
`define CIF_IDX_DSG 4'h1
`define CIF_IDX_CTRL 4'h3
`define CIF_IDX_ICHG 4'h4
`define CIF_IDX_VREG 4'h6
`define CIF_IDX_COOL 4'h7
`define CIF_BIT_CHG_EN 4
`define CIF_BIT_BOOST_EN 5
`define CIF_BIT_WARM_OPT 4
`define CIF_BIT_COOL_OPT 0
`define CIF_CTRL_RST 8'h10
`define CIF_VREG_DROP 6'h09
`define CIF_STRETCH 2'd2
`define CIF_BLINK_HALF 125000000
`endif

// *** cif_pkg.sv ***
// Types for the charger serial port and fault reporting block
`default_nettype none
package cif_pkg;
	typedef enum logic [3:0] {
		CIF_IDLE = 4'h0,
		CIF_ADDR = 4'h1,
		CIF_AACK = 4'h3,
		CIF_REG = 4'h2,
		CIF_RACK = 4'h6,
		CIF_WR = 4'h7,
		CIF_WACK = 4'h5,
		CIF_RD = 4'h4,
		CIF_RDACK = 4'hc
	} cif_state_e_t;

	typedef struct packed {
		logic boost_ovp;
		logic bat_ovp;
		logic sys_short;
		logic [1:0] chg_fault;
		logic [2:0] therm;
	} cif_fault_in_t;

	typedef struct packed {
		logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
		cif_state_e_t st;
		logic [3:0] bitc;
		logic [7:0] sh;
		logic rd, mack, busy, sda_oe, scl_oe;
		logic [1:0] strc;
		logic [7:0] idx;
		logic [9:0][7:0] regs;
		logic [7:0] flt;
		logic armed, seen, irq, bsw_off;
		logic [26:0] blink_cnt;
		logic blink;
		logic [5:0] vreg;
		logic [6:0] ichg;
		logic ap_v, ap_w;
		logic [5:0] ap_i;
		logic [31:0] hrdata;
	} cif_state_t;
endpackage
`default_nettype wire

// *** cif_charger_i2c.sv ***
// Charger serial slave port, register file and fault reporting
`timescale 1ns/1ps
`default_nettype none
`include "cif_consts.svh"

module cif_charger_i2c #(
	parameter int unsigned BLINK_HALF = `CIF_BLINK_HALF
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire cif_pkg::cif_fault_in_t flt_in,
	input wire logic temp_warm,
	input wire logic temp_cool,
	input wire logic temp_dsg_ok,
	input wire logic adapter_in,
	input wire logic qon_event,
	output logic fault_int,
	output logic charge_en,
	output logic boost_run,
	output logic bsw_off,
	output logic discharge_en,
	output logic [5:0] vreg_target,
	output logic [6:0] ichg_target,
	output logic [1:0] dsg_thr_sel,
	output logic stat_out,
	output logic stat_oe
);
	// ****************************************
	// Decoding helpers
	// ****************************************
	function automatic logic idx_ok(input logic [7:0] i);
		idx_ok = (i <= `CIF_IDX_WARM) || (i == `CIF_IDX_FAULT);
	endfunction

	// Only 0x00-0x07 chain; everything else ends a write burst, while reads go on with 0x00
	function automatic logic [7:0] idx_next(input logic [7:0] i);
		idx_next = (i < `CIF_IDX_MULTI_END) ? i + 8'h01 : `CIF_IDX_BAD;
	endfunction

	cif_pkg::cif_state_t s, next_s;
	logic scl_rise, scl_fall, ev_start, ev_stop;
	logic [7:0] live, rbyte;
	logic flt_rd, ap_take, ap_ok;

	// Synchronised levels only; first stage feeds nothing else
	assign scl_rise = s.scl_s && !s.scl_p;
	assign scl_fall = !s.scl_s && s.scl_p;
	assign ev_start = s.scl_s && s.scl_p && s.sda_p && !s.sda_s;
	assign ev_stop = s.scl_s && s.scl_p && !s.sda_p && s.sda_s;
	assign live = {1'b0, flt_in.boost_ovp, flt_in.chg_fault,
		flt_in.bat_ovp, flt_in.therm};
	assign rbyte = (s.idx == `CIF_IDX_FAULT) ? s.flt :
		idx_ok(s.idx) ? s.regs[s.idx[3:0]] : 8'h00;
	assign flt_rd = (s.st == cif_pkg::CIF_RD) && (s.strc == 2'd1) &&
		(s.idx == `CIF_IDX_FAULT);
	assign ap_take = hsel && htrans[1] && hready;
	assign ap_ok = (haddr[7:2] <= 6'(`CIF_IDX_WARM)) ||
		(haddr[7:2] == 6'(`CIF_IDX_FAULT));

	always_comb begin
		next_s = s;
		next_s.scl_m = scl_in;
		next_s.scl_s = s.scl_m;
		next_s.scl_p = s.scl_s;
		next_s.sda_m = sda_in;
		next_s.sda_s = s.sda_m;
		next_s.sda_p = s.sda_s;

		// ****************************************
		// Register bus slave
		// ****************************************
		next_s.ap_v = ap_take;
		next_s.ap_w = hwrite;
		next_s.ap_i = ap_ok ? haddr[7:2] : 6'h3f;
		if (ap_take && !hwrite) begin
			// Only writable words forward; fault and unmapped writes are dropped
			if (s.ap_v && s.ap_w && s.ap_i == haddr[7:2] &&
				s.ap_i <= 6'(`CIF_IDX_WARM))
				next_s.hrdata = {24'h0, hwdata[7:0]};
			else if (haddr[7:2] == 6'(`CIF_IDX_FAULT))
				next_s.hrdata = {24'h0, s.flt};
			else if (ap_ok)
				next_s.hrdata = {24'h0, s.regs[haddr[5:2]]};
			else
				next_s.hrdata = 32'h0;
		end
		if (s.ap_v && s.ap_w && s.ap_i <= 6'(`CIF_IDX_WARM))
			next_s.regs[s.ap_i[3:0]] = hwdata[7:0];

		// ****************************************
		// Serial slave
		// ****************************************
		if (ev_start) begin
			next_s.st = cif_pkg::CIF_ADDR;
			next_s.busy = 1'b1;
			next_s.bitc = 4'h0;
			next_s.sda_oe = 1'b0;
			next_s.scl_oe = 1'b0;
		end else if (ev_stop) begin
			next_s.st = cif_pkg::CIF_IDLE;
			next_s.busy = 1'b0;
			next_s.sda_oe = 1'b0;
			next_s.scl_oe = 1'b0;
		end else begin
			if (scl_rise) begin
				case (s.st)
				cif_pkg::CIF_ADDR, cif_pkg::CIF_REG, cif_pkg::CIF_WR: begin
					next_s.sh = {s.sh[6:0], s.sda_s};
					next_s.bitc = s.bitc + 4'h1;
				end
				cif_pkg::CIF_RDACK: next_s.mack = !s.sda_s;
				default: ;
				endcase
			end
			if (s.st == cif_pkg::CIF_RD && s.strc != 2'd0) begin
				next_s.strc = s.strc - 2'd1;
				if (s.strc == 2'd1) begin
					// Byte loaded and first bit set in the same cycle as release
					next_s.sda_oe = !rbyte[7];
					next_s.sh = {rbyte[6:0], 1'b0};
					next_s.bitc = 4'h1;
					next_s.scl_oe = 1'b0;
				end
			end else if (scl_fall) begin
				case (s.st)
				cif_pkg::CIF_ADDR: if (s.bitc == 4'h8) begin
					if (s.sh[7:1] == `CIF_SLV_ADDR) begin
						next_s.rd = s.sh[0];
						next_s.sda_oe = 1'b1;
						next_s.st = cif_pkg::CIF_AACK;
					end else begin
						next_s.st = cif_pkg::CIF_IDLE;
					end
				end
				cif_pkg::CIF_AACK: begin
					next_s.sda_oe = 1'b0;
					next_s.bitc = 4'h0;
					if (s.rd) begin
						next_s.st = cif_pkg::CIF_RD;
						next_s.strc = `CIF_STRETCH;
						next_s.scl_oe = 1'b1;
					end else begin
						next_s.st = cif_pkg::CIF_REG;
					end
				end
				cif_pkg::CIF_REG: if (s.bitc == 4'h8) begin
					next_s.idx = s.sh;
					if (idx_ok(s.sh)) begin
						next_s.sda_oe = 1'b1;
						next_s.st = cif_pkg::CIF_RACK;
					end else begin
						next_s.st = cif_pkg::CIF_IDLE;
					end
				end
				cif_pkg::CIF_RACK, cif_pkg::CIF_WACK: begin
					next_s.sda_oe = 1'b0;
					next_s.bitc = 4'h0;
					next_s.st = cif_pkg::CIF_WR;
					if (s.st == cif_pkg::CIF_WACK)
						next_s.idx = idx_next(s.idx);
				end
				cif_pkg::CIF_WR: if (s.bitc == 4'h8) begin
					if (idx_ok(s.idx)) begin
						if (s.idx <= `CIF_IDX_WARM)
							next_s.regs[s.idx[3:0]] = s.sh;
						next_s.sda_oe = 1'b1;
						next_s.st = cif_pkg::CIF_WACK;
					end else begin
						next_s.st = cif_pkg::CIF_IDLE;
					end
				end
				cif_pkg::CIF_RD: begin
					if (s.bitc == 4'h8) begin
						next_s.sda_oe = 1'b0;
						next_s.st = cif_pkg::CIF_RDACK;
					end else begin
						next_s.sda_oe = !s.sh[7];
						next_s.sh = {s.sh[6:0], 1'b0};
						next_s.bitc = s.bitc + 4'h1;
					end
				end
				cif_pkg::CIF_RDACK: begin
					if (s.mack) begin
						next_s.idx = idx_next(s.idx);
						next_s.st = cif_pkg::CIF_RD;
						next_s.strc = `CIF_STRETCH;
						next_s.scl_oe = 1'b1;
					end else begin
						next_s.st = cif_pkg::CIF_IDLE;
					end
				end
				default: ;
				endcase
			end
		end

		// ****************************************
		// Fault latch and interrupt
		// ****************************************
		// New faults in bits 7:3 are OR'd after the clear, so they are never lost; bits 2:0 follow flt_in.therm live
		next_s.flt = (flt_rd ? 8'h00 : s.flt) | live;
		next_s.flt[2:0] = flt_in.therm;
		if (flt_rd) begin
			next_s.irq = 1'b0;
			next_s.seen = 1'b1;
		end
		if (!s.armed && s.seen && live == 8'h00)
			next_s.armed = 1'b1;
		if (s.armed && live != 8'h00) begin
			next_s.irq = 1'b1;
			next_s.armed = 1'b0;
			next_s.seen = 1'b0;
		end
		if (flt_in.boost_ovp)
			next_s.regs[`CIF_IDX_CTRL][`CIF_BIT_BOOST_EN] = 1'b0;
		if (flt_in.sys_short)
			next_s.bsw_off = 1'b1;
		else if (adapter_in || qon_event)
			next_s.bsw_off = 1'b0;

		// ****************************************
		// Temperature window targets
		// ****************************************
		next_s.vreg = s.regs[`CIF_IDX_VREG][7:2];
		if (temp_warm && !s.regs[`CIF_IDX_WARM][`CIF_BIT_WARM_OPT])
			next_s.vreg = (next_s.vreg > `CIF_VREG_DROP) ?
				next_s.vreg - `CIF_VREG_DROP : 6'h00;
		next_s.ichg = s.regs[`CIF_IDX_ICHG][6:0];
		if (temp_cool)
			next_s.ichg = s.regs[`CIF_IDX_COOL][`CIF_BIT_COOL_OPT] ?
				7'(s.regs[`CIF_IDX_ICHG][6:0] / 7'd5) :
				{1'b0, s.regs[`CIF_IDX_ICHG][6:1]};
		if (s.blink_cnt >= 27'(BLINK_HALF - 1)) begin
			next_s.blink_cnt = 27'h0;
			next_s.blink = !s.blink;
		end else begin
			next_s.blink_cnt = s.blink_cnt + 27'h1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
			s.scl_m <= 1'b1;
			s.scl_s <= 1'b1;
			s.scl_p <= 1'b1;
			s.sda_m <= 1'b1;
			s.sda_s <= 1'b1;
			s.sda_p <= 1'b1;
			s.st <= cif_pkg::CIF_IDLE;
			s.idx <= `CIF_IDX_BAD;
			s.regs[`CIF_IDX_CTRL] <= `CIF_CTRL_RST;
			s.armed <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s.hrdata;
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe = s.scl_oe;
	assign sda_oe = s.sda_oe;
	assign fault_int = s.irq;
	assign charge_en = s.regs[`CIF_IDX_CTRL][`CIF_BIT_CHG_EN] &&
		!flt_in.bat_ovp && flt_in.therm == 3'h0;
	assign boost_run = s.regs[`CIF_IDX_CTRL][`CIF_BIT_BOOST_EN] &&
		!flt_in.boost_ovp;
	assign bsw_off = s.bsw_off;
	assign discharge_en = temp_dsg_ok;
	assign dsg_thr_sel = s.regs[`CIF_IDX_DSG][7:6];
	assign vreg_target = s.vreg;
	assign ichg_target = s.ichg;
	assign stat_out = 1'b0;
	// Pin low while charging, blinks while a thermistor fault suspends
	assign stat_oe = charge_en ||
		(flt_in.therm != 3'h0 && s.blink);

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence stretch_held;
		scl_oe [*2];
	endsequence

	a_addr_match: assert property (
		$rose(s.st == cif_pkg::CIF_AACK) |->
			$past(s.sh[7:1]) == `CIF_SLV_ADDR && sda_oe)
		else $error("ack given to foreign address");
	a_sda_low_clk: assert property (
		$changed(sda_oe) |->
			!$past(s.scl_s) || $past(ev_start || ev_stop))
		else $error("data changed while clock high");
	a_bad_index: assert property (
		s.st == cif_pkg::CIF_REG && scl_fall && !ev_start &&
		!ev_stop && s.bitc == 4'h8 && !idx_ok(s.sh) |=>
			s.st == cif_pkg::CIF_IDLE && !sda_oe)
		else $error("undefined index not refused");
	a_idx_step: assert property (
		s.st == cif_pkg::CIF_WACK && scl_fall && !ev_start &&
		!ev_stop && s.idx < 8'h08 |=> s.idx == $past(s.idx) + 8'h01)
		else $error("index not advanced");
	a_stretch_len: assert property (
		$rose(scl_oe) |-> stretch_held ##1 !scl_oe)
		else $error("clock stretch length wrong");
	a_fault_clear: assert property (
		flt_rd |=> s.flt[7:3] == $past(live[7:3]))
		else $error("fault register not refreshed after read");
	a_int_once: assert property (
		$rose(fault_int) |-> $past(s.armed) && $past(live) != 8'h00)
		else $error("interrupt raised while disarmed");
	a_boost_off: assert property (
		flt_in.boost_ovp |=>
			!s.regs[`CIF_IDX_CTRL][`CIF_BIT_BOOST_EN])
		else $error("boost enable kept on overvoltage");
	a_chg_off: assert property (
		flt_in.bat_ovp |-> !charge_en ##1 s.flt[3])
		else $error("charging kept on battery overvoltage");
	a_bsw_latch: assert property (
		flt_in.sys_short |=> bsw_off)
		else $error("battery switch not latched off");
	a_therm_live: assert property (
		##1 s.flt[2:0] == $past(flt_in.therm))
		else $error("thermistor field not live");
	a_busy_frame: assert property (
		s.st != cif_pkg::CIF_IDLE |-> s.busy)
		else $error("frame active while bus free");
endmodule
`default_nettype wire

// *** cif_host_model.sv ***
// Bus master model for the charger serial port
`timescale 1ns/1ps
`default_nettype none
module cif_host_model (
	input wire logic scl_oe,
	input wire logic sda_oe,
	output logic scl,
	output logic sda,
	output logic hang
);
	// ****
	// Open-drain wires, pulled up when released
	// ****
	logic scl_lo = 1'b0;
	logic sda_lo = 1'b0;
	assign scl = !(scl_lo | scl_oe);
	assign sda = !(sda_lo | sda_oe);
	initial hang = 1'b0;
	// ****
	// Bit, byte and framing
	// ****
	task automatic bitx(input logic b, output logic r);
		int n;
		sda_lo = !b;
		#31.25 scl_lo = 1'b0;
		n = 0;
		// Slave may stretch; never wait forever
		while (!scl && n < 400) begin
			#1 n++;
		end
		if (n >= 400)
			hang = 1'b1;
		#31.25 r = sda;
		#31.25 scl_lo = 1'b1;
		#31.25;
	endtask
	task automatic start;
		sda_lo = 1'b0;
		#31.25 scl_lo = 1'b0;
		#62.5 sda_lo = 1'b1;
		#31.25 scl_lo = 1'b1;
		#31.25;
	endtask
	task automatic stop;
		sda_lo = 1'b1;
		#31.25 scl_lo = 1'b0;
		#31.25 sda_lo = 1'b0;
		#31.25;
	endtask
	task automatic wbyte(input logic [7:0] v, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitx(v[i], r);
		bitx(1'b1, r);
		ack = !r;
	endtask
	task automatic rbyte(input logic ack, output logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitx(1'b1, v[i]);
		bitx(!ack, r);
	endtask
endmodule
`default_nettype wire

// *** charger_i2c_slave_fault_report_tb.sv ***
// Self-checking bench for the charger serial port
`timescale 1ns/1ps
`default_nettype none
module charger_i2c_slave_fault_report_tb;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic hreadyout, scl, sda, scl_oe, sda_oe, hang, ack, p;
	logic fault_int, charge_en, boost_run, bsw_off, discharge_en, stat_oe;
	logic temp_warm = 1'b0, temp_cool = 1'b0, temp_dsg_ok = 1'b0;
	logic adapter_in = 1'b0, qon_event = 1'b0;
	logic [5:0] vreg_target;
	logic [6:0] ichg_target;
	logic [1:0] dsg_thr_sel;
	logic [7:0] d;
	logic [7:0] rd [4];
	cif_pkg::cif_fault_in_t flt_in = '0;
	int mismatches = 0, check_count = 0, n;
	always #2 hclk = !hclk;
	cif_charger_i2c #(.BLINK_HALF(8)) dut_u (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hwdata, .hready(hreadyout), .hreadyout, .hresp(), .hrdata,
		.scl_in(scl), .scl_out(), .scl_oe, .sda_in(sda), .sda_out(),
		.sda_oe, .flt_in, .temp_warm, .temp_cool, .temp_dsg_ok, .adapter_in,
		.qon_event, .fault_int, .charge_en, .boost_run, .bsw_off,
		.discharge_en, .vreg_target, .ichg_target, .dsg_thr_sel,
		.stat_out(), .stat_oe
	);
	cif_host_model host_u (.scl_oe, .sda_oe, .scl, .sda, .hang);
	// ****
	// Checking and bus tasks
	// ****
	task automatic chk(input string s, input logic [7:0] v, e);
		check_count++;
		if (v !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", s, e, v);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic wt(input int c);
		repeat (c) @(posedge hclk);
	endtask
	task automatic rdy;
		int k;
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while (hreadyout !== 1'b1 && k < 50);
		if (hreadyout !== 1'b1) begin
			mismatches++;
			end_sim;
		end
	endtask
	task automatic ahb(input logic w, input logic [7:0] i, wd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {22'h0, i, 2'h0};
		rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		rdy;
		d = hrdata[7:0];
	endtask
	task automatic sb(input logic [7:0] b, input logic ea, input string s);
		host_u.wbyte(b, ack);
		chk(s, 8'(ack), 8'(ea));
	endtask
	task automatic srd(input logic [7:0] i, input int c);
		host_u.start;
		sb(8'hd4, 1'b1, "wr addr");
		sb(i, 1'b1, "index");
		host_u.start;
		sb(8'hd5, 1'b1, "rd addr");
		for (int k = 0; k < c; k++)
			host_u.rbyte(k < c - 1, rd[k]);
		host_u.stop;
		d = rd[0];
	endtask
	// ****
	// Test sequence
	// ****
	initial begin
		wt(6);
		hresetn <= 1'b1;
		wt(4);
		ahb(1'b0, 8'h03, 8'h00);
		chk("ctrl", d, 8'h10);
		ahb(1'b0, 8'h0c, 8'h00);
		chk("fault", d, 8'h00);
		ahb(1'b1, 8'h0a, 8'h77);
		ahb(1'b0, 8'h0a, 8'h00);
		chk("unmapped", d, 8'h00);
		$display("test 1 done");
		host_u.start;
		sb(8'hd6, 1'b0, "foreign");
		host_u.stop;
		host_u.start;
		sb(8'hd4, 1'b1, "addr");
		sb(8'h07, 1'b1, "index");
		sb(8'h5a, 1'b1, "data 7");
		sb(8'ha5, 1'b1, "data 8");
		sb(8'h3c, 1'b0, "past end");
		host_u.stop;
		ahb(1'b0, 8'h07, 8'h00);
		chk("reg 7", d, 8'h5a);
		ahb(1'b0, 8'h08, 8'h00);
		chk("reg 8", d, 8'ha5);
		host_u.start;
		sb(8'hd4, 1'b1, "addr");
		sb(8'h0a, 1'b0, "bad index");
		host_u.stop;
		$display("test 2 done");
		for (int i = 0; i < 3; i++)
			ahb(1'b1, 8'(i), 8'h80 + 8'(i));
		srd(8'h00, 3);
		for (int i = 0; i < 3; i++)
			chk("burst rd", rd[i], 8'h80 + 8'(i));
		chk("thr sel", 8'(dsg_thr_sel), 8'h02);
		$display("test 3 done");
		ahb(1'b1, 8'h06, 8'h80);
		ahb(1'b1, 8'h04, 8'h64);
		ahb(1'b1, 8'h09, 8'h00);
		ahb(1'b1, 8'h07, 8'h01);
		temp_warm <= 1'b1;
		temp_cool <= 1'b1;
		wt(3);
		chk("vreg warm", 8'(vreg_target), 8'h17);
		chk("ichg cool", 8'(ichg_target), 8'h14);
		ahb(1'b1, 8'h09, 8'h10);
		ahb(1'b1, 8'h07, 8'h00);
		wt(3);
		chk("vreg warm", 8'(vreg_target), 8'h20);
		chk("ichg cool", 8'(ichg_target), 8'h32);
		temp_cool <= 1'b0;
		wt(3);
		chk("ichg", 8'(ichg_target), 8'h64);
		$display("test 4 done");
		ahb(1'b1, 8'h03, 8'h30);
		wt(2);
		chk("boost", 8'(boost_run), 8'h01);
		chk("status chg", 8'(stat_oe), 8'h01);
		flt_in.bat_ovp <= 1'b1;
		wt(3);
		chk("chg en", 8'(charge_en), 8'h00);
		chk("irq", 8'(fault_int), 8'h01);
		srd(8'h0c, 1);
		chk("fault 1st", d, 8'h08);
		chk("irq", 8'(fault_int), 8'h00);
		flt_in.boost_ovp <= 1'b1;
		wt(3);
		chk("boost", 8'(boost_run), 8'h00);
		chk("irq", 8'(fault_int), 8'h00);
		flt_in.boost_ovp <= 1'b0;
		flt_in.bat_ovp <= 1'b0;
		ahb(1'b0, 8'h03, 8'h00);
		chk("ctrl", d, 8'h10);
		srd(8'h0c, 1);
		chk("fault latch", d & 8'h40, 8'h40);
		srd(8'h0c, 1);
		chk("fault live", d, 8'h00);
		flt_in.boost_ovp <= 1'b1;
		wt(3);
		chk("irq", 8'(fault_int), 8'h01);
		flt_in.boost_ovp <= 1'b0;
		host_u.start;
		sb(8'hd4, 1'b1, "addr");
		sb(8'h0c, 1'b1, "fault idx");
		sb(8'h55, 1'b1, "fault wr");
		sb(8'h55, 1'b0, "fault burst");
		host_u.stop;
		$display("test 5 done");
		flt_in.sys_short <= 1'b1;
		wt(2);
		flt_in.sys_short <= 1'b0;
		wt(3);
		chk("bsw", 8'(bsw_off), 8'h01);
		adapter_in <= 1'b1;
		wt(3);
		chk("bsw", 8'(bsw_off), 8'h00);
		adapter_in <= 1'b0;
		flt_in.sys_short <= 1'b1;
		wt(2);
		flt_in.sys_short <= 1'b0;
		wt(2);
		chk("bsw", 8'(bsw_off), 8'h01);
		qon_event <= 1'b1;
		wt(3);
		chk("bsw", 8'(bsw_off), 8'h00);
		qon_event <= 1'b0;
		flt_in.chg_fault <= 2'h2;
		wt(2);
		flt_in.chg_fault <= 2'h0;
		ahb(1'b0, 8'h0c, 8'h00);
		chk("chg fault", d & 8'h30, 8'h20);
		$display("test 6 done");
		flt_in.therm <= 3'h2;
		ahb(1'b0, 8'h0c, 8'h00);
		chk("thermistor", d & 8'h07, 8'h02);
		chk("chg en", 8'(charge_en), 8'h00);
		n = 0;
		p = stat_oe;
		repeat (40) begin
			@(posedge hclk);
			if (stat_oe !== p)
				n++;
			p = stat_oe;
		end
		chk("status blink", 8'(n >= 2), 8'h01);
		flt_in.therm <= 3'h0;
		temp_dsg_ok <= 1'b1;
		wt(2);
		chk("dsg", 8'(discharge_en), 8'h01);
		temp_dsg_ok <= 1'b0;
		wt(2);
		chk("dsg", 8'(discharge_en), 8'h00);
		chk("link hang", 8'(hang), 8'h00);
		$display("test 7 done");
		end_sim;
	end
endmodule
`default_nettype wire
